/* File: core/cmd_timing_pkg.sv */
// Constants, field layout and command encoding for the memory command timing block.
// Assumes an APB slave at 32-bit data; one pclk edge counts as one command or memory clock.
//
// Contract
// - A write then a read to a different row are spaced 3 clocks, or 2 when bit 29 is set.
// - A write then a read to the same row wait for the write-to-read recovery time instead.
// - A read then a write to any row are spaced 5 clocks, or 4 when bit 28 is set.
// - Two reads to different rows are spaced 4 clocks, or 3 when bit 27 is set.
// - Read-delay code 000/001/010 schedules read return 7/6/5 clocks after capture.
// - Activate-to-precharge code 00/01/10 gives at least 7/6/5 clocks.
// - Read latency code 00/01/10 means 2.5/2/1.5 clocks from read command to data.
// - Activate to write takes 3 clocks, or 2 when bit 3 is set.
// - Activate to read takes 3 clocks, or 2 when bit 1 is set.
// - Precharge to activate of the same row takes 3 clocks, or 2 when bit 0 is set.
// - After reset the timing register holds 0x00000010.
package cmd_timing_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] TIMING_OFFSET   = 12'h078;
  localparam logic [31:0] TIMING_RESET    = 32'h0000_0010;
  localparam logic [31:0] TIMING_WR_MASK  = 32'h3F00_063B;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int WR_RD_FAST_BIT   = 29;
  localparam int RD_WR_FAST_BIT   = 28;
  localparam int RD_RD_FAST_BIT   = 27;
  localparam int RD_DELAY_LSB     = 24;
  localparam int ACT_PRE_LSB      = 9;
  localparam int LATENCY_LSB      = 4;
  localparam int ACT_WR_FAST_BIT  = 3;
  localparam int ACT_RD_FAST_BIT  = 1;
  localparam int PRE_ACT_FAST_BIT = 0;

  // ---------------------------------------------------------------------------
  // Spacing counts in clocks, read latency values in half clocks
  // ---------------------------------------------------------------------------
  localparam int          CNT_W       = 4;
  localparam logic [3:0]  CNT_MAX     = 4'hF;
  localparam logic [3:0]  WR_RD_SLOW  = 4'h3;
  localparam logic [3:0]  WR_RD_FAST  = 4'h2;
  localparam logic [3:0]  RD_WR_SLOW  = 4'h5;
  localparam logic [3:0]  RD_WR_FAST  = 4'h4;
  localparam logic [3:0]  RD_RD_SLOW  = 4'h4;
  localparam logic [3:0]  RD_RD_FAST  = 4'h3;
  localparam logic [3:0]  RCD_SLOW    = 4'h3;
  localparam logic [3:0]  RCD_FAST    = 4'h2;
  localparam logic [3:0]  RP_SLOW     = 4'h3;
  localparam logic [3:0]  RP_FAST     = 4'h2;
  localparam logic [3:0]  ACT_PRE_7   = 4'h7;
  localparam logic [3:0]  ACT_PRE_6   = 4'h6;
  localparam logic [3:0]  ACT_PRE_5   = 4'h5;
  localparam int          RET_DEPTH   = 6;
  localparam logic [2:0]  LAT_HALF_25 = 3'h5;
  localparam logic [2:0]  LAT_HALF_20 = 3'h4;
  localparam logic [2:0]  LAT_HALF_15 = 3'h3;
  localparam logic [2:0]  LAT_RESET   = 3'h4;

  // ---------------------------------------------------------------------------
  // Command kinds
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_ACT,
    OP_PRE,
    OP_RD,
    OP_WR
  } cmd_op_e;

endpackage : cmd_timing_pkg

/* File: core/dram_command_timing_control.sv */
// Memory command spacing and read-return scheduling with its APB timing register.
// Assumes a requester that holds cmd_req with op and row until cmd_ack, and a
// synchronous APB master on pclk.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
module dram_command_timing_control #(
  parameter int         ROWS      = 8,
  parameter int         ROW_W     = 3,
  parameter logic [3:0] WTR_COUNT = 4'h2
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output      logic [31:0]                 prdata,
  output      logic                        pready,
  output      logic                        pslverr,
  // Command request from the scheduler
  input  wire logic                        cmd_req,
  input  wire cmd_timing_pkg::cmd_op_e     cmd_op,
  input  wire logic [ROW_W-1:0]            cmd_row,
  output      logic                        cmd_ack,
  // Command issued to the memory channel
  output      logic                        mem_cmd_valid,
  output      cmd_timing_pkg::cmd_op_e     mem_cmd_op,
  output      logic [ROW_W-1:0]            mem_cmd_row,
  // Read return scheduling
  input  wire logic                        rd_capture,
  output      logic                        rd_return,
  // Read latency in half clocks
  output      logic [2:0]                  read_latency_half
);
  import cmd_timing_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [31:0]           timing_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [31:0]           prdata_q;
  logic                  issue_q;
  cmd_op_e               op_q;
  logic [ROW_W-1:0]      row_q;
  logic [CNT_W-1:0]      since_wr_q;
  logic [CNT_W-1:0]      since_rd_q;
  logic [ROW_W-1:0]      wr_row_q;
  logic [ROW_W-1:0]      rd_row_q;
  logic [CNT_W-1:0]      since_act_q [ROWS];
  logic [CNT_W-1:0]      since_pre_q [ROWS];
  logic [ROWS-1:0]       open_q;
  logic [RET_DEPTH-1:0]  ret_sr_q;
  logic                  rd_return_q;
  logic [2:0]            lat_q;
  logic                  hit;
  logic                  wr_access;
  logic [3:0]            wr_rd_gap;
  logic [3:0]            rd_wr_gap;
  logic [3:0]            rd_rd_gap;
  logic [3:0]            rcd_wr;
  logic [3:0]            rcd_rd;
  logic [3:0]            rp_gap;
  logic [3:0]            act_pre_gap;
  logic [2:0]            ret_tap;
  logic                  allow;
  logic                  issue_now;

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------

  // Decode and write strobe at the completing access edge
  assign hit       = (paddr == TIMING_OFFSET);
  assign wr_access = psel & penable & pready_q & pwrite & hit;

  // Zero wait state answer, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit;
      if (psel && !penable) begin
        prdata_q <= (hit && !pwrite) ? timing_q : 32'h0000_0000;
      end
    end
  end

  // Timing register, reserved bits held at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_q <= TIMING_RESET;
    end else if (wr_access) begin
      timing_q <= pwdata & TIMING_WR_MASK;
    end
  end

  // ---------------------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------------------

  // Turnaround and delay selections
  assign wr_rd_gap = timing_q[WR_RD_FAST_BIT]   ? WR_RD_FAST : WR_RD_SLOW;
  assign rd_wr_gap = timing_q[RD_WR_FAST_BIT]   ? RD_WR_FAST : RD_WR_SLOW;
  assign rd_rd_gap = timing_q[RD_RD_FAST_BIT]   ? RD_RD_FAST : RD_RD_SLOW;
  assign rcd_wr    = timing_q[ACT_WR_FAST_BIT]  ? RCD_FAST   : RCD_SLOW;
  assign rcd_rd    = timing_q[ACT_RD_FAST_BIT]  ? RCD_FAST   : RCD_SLOW;
  assign rp_gap    = timing_q[PRE_ACT_FAST_BIT] ? RP_FAST    : RP_SLOW;

  // Activate-to-precharge, reserved code falls back to slowest
  always_comb begin
    case (timing_q[ACT_PRE_LSB +: 2])
      2'h1:    act_pre_gap = ACT_PRE_6;
      2'h2:    act_pre_gap = ACT_PRE_5;
      default: act_pre_gap = ACT_PRE_7;
    endcase
  end

  // Return tap: delay of d clocks reads shift stage d-2
  always_comb begin
    case (timing_q[RD_DELAY_LSB +: 3])
      3'h1:    ret_tap = 3'h4;
      3'h2:    ret_tap = 3'h3;
      default: ret_tap = 3'h5;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Command admission
  // ---------------------------------------------------------------------------

  // Check the request against every spacing that applies to it
  always_comb begin
    allow = 1'b0;
    case (cmd_op)
      OP_ACT: begin
        allow = !open_q[cmd_row] && (since_pre_q[cmd_row] >= rp_gap);
      end
      OP_PRE: begin
        allow = open_q[cmd_row] && (since_act_q[cmd_row] >= act_pre_gap);
      end
      OP_RD: begin
        allow = open_q[cmd_row] && (since_act_q[cmd_row] >= rcd_rd);
        if (wr_row_q == cmd_row) begin
          allow = allow && (since_wr_q >= WTR_COUNT);
        end else begin
          allow = allow && (since_wr_q >= wr_rd_gap);
        end
        if (rd_row_q != cmd_row) begin
          allow = allow && (since_rd_q >= rd_rd_gap);
        end
      end
      OP_WR: begin
        allow = open_q[cmd_row] && (since_act_q[cmd_row] >= rcd_wr)
                && (since_rd_q >= rd_wr_gap);
      end
      default: allow = 1'b0;
    endcase
  end

  // The cycle after an issue is skipped so a held request is not taken twice
  assign issue_now = cmd_req & allow & ~issue_q;

  // Issued command register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      issue_q <= 1'b0;
      op_q    <= OP_ACT;
      row_q   <= '0;
    end else begin
      issue_q <= issue_now;
      if (issue_now) begin
        op_q  <= cmd_op;
        row_q <= cmd_row;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Spacing counters
  // ---------------------------------------------------------------------------

  // Clocks since the last write, with its row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_wr_q <= CNT_MAX;
      wr_row_q   <= '0;
    end else if (issue_now && cmd_op == OP_WR) begin
      since_wr_q <= 4'h1;
      wr_row_q   <= cmd_row;
    end else if (since_wr_q != CNT_MAX) begin
      since_wr_q <= since_wr_q + 4'h1;
    end
  end

  // Clocks since the last read, with its row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rd_q <= CNT_MAX;
      rd_row_q   <= '0;
    end else if (issue_now && cmd_op == OP_RD) begin
      since_rd_q <= 4'h1;
      rd_row_q   <= cmd_row;
    end else if (since_rd_q != CNT_MAX) begin
      since_rd_q <= since_rd_q + 4'h1;
    end
  end

  // Per-row activate and precharge age and open state
  for (genvar r = 0; r < ROWS; r++) begin : g_row
    logic sel;
    assign sel = issue_now && (cmd_row == ROW_W'(r));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        since_act_q[r] <= CNT_MAX;
        since_pre_q[r] <= CNT_MAX;
        open_q[r]      <= 1'b0;
      end else begin
        if (sel && cmd_op == OP_ACT) begin
          since_act_q[r] <= 4'h1;
          open_q[r]      <= 1'b1;
        end else if (since_act_q[r] != CNT_MAX) begin
          since_act_q[r] <= since_act_q[r] + 4'h1;
        end
        if (sel && cmd_op == OP_PRE) begin
          since_pre_q[r] <= 4'h1;
          open_q[r]      <= 1'b0;
        end else if (since_pre_q[r] != CNT_MAX) begin
          since_pre_q[r] <= since_pre_q[r] + 4'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read return and latency
  // ---------------------------------------------------------------------------

  // Captured reads walk the shift register until their delay is reached
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_sr_q    <= '0;
      rd_return_q <= 1'b0;
    end else begin
      ret_sr_q    <= {ret_sr_q[RET_DEPTH-2:0], rd_capture};
      rd_return_q <= ret_sr_q[ret_tap];
    end
  end

  // Read latency in half clocks, reserved code shown as the slowest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_q <= LAT_RESET;
    end else begin
      case (timing_q[LATENCY_LSB +: 2])
        2'h0:    lat_q <= LAT_HALF_25;
        2'h1:    lat_q <= LAT_HALF_20;
        2'h2:    lat_q <= LAT_HALF_15;
        default: lat_q <= LAT_HALF_25;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign cmd_ack           = issue_q;
  assign mem_cmd_valid     = issue_q;
  assign mem_cmd_op        = op_q;
  assign mem_cmd_row       = row_q;
  assign rd_return         = rd_return_q;
  assign read_latency_half = lat_q;

endmodule : dram_command_timing_control

/* File: test/cmd_timing_asserts.sv */
// Checker for APB answers, command spacing and read return.
// Sees only the top ports; bound at the foot of this file.
`timescale 1ns/10ps
module cmd_timing_asserts #(
  parameter int         ROW_W     = 3,
  parameter logic [3:0] WTR_COUNT = 4'h2
) (
  // Clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // APB
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // Commands and read return
  input wire logic                    cmd_ack,
  input wire logic                    mem_cmd_valid,
  input wire cmd_timing_pkg::cmd_op_e mem_cmd_op,
  input wire logic [ROW_W-1:0]        mem_cmd_row,
  input wire logic                    rd_capture,
  input wire logic                    rd_return
);
  import cmd_timing_pkg::*;
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  logic [31:0]      sh_q;
  logic [3:0]       since_q;
  cmd_op_e          last_op_q;
  logic [ROW_W-1:0] last_row_q;
  logic             same;
  logic [3:0]       act_pre_n;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign same   = (mem_cmd_row == last_row_q);
  assign act_pre_n = (sh_q[10:9] == 2'h1) ? ACT_PRE_6 : (sh_q[10:9] == 2'h2) ? ACT_PRE_5 : ACT_PRE_7;
  // Shadow of the timing word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sh_q <= TIMING_RESET;
    else if (psel && penable && pready && pwrite && paddr == TIMING_OFFSET) sh_q <= pwdata & TIMING_WR_MASK;
  end
  // Cycles since last issue, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_q    <= CNT_MAX;
      last_op_q  <= OP_ACT;
      last_row_q <= '0;
    end else if (mem_cmd_valid) begin
      since_q    <= 4'h1;
      last_op_q  <= mem_cmd_op;
      last_row_q <= mem_cmd_row;
    end else if (since_q != CNT_MAX) since_q <= since_q + 4'h1;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_pair(cmd_op_e a, cmd_op_e b);
    mem_cmd_valid && last_op_q == a && mem_cmd_op == b;
  endsequence
  property p_gap(cmd_op_e a, cmd_op_e b, logic pick, logic [3:0] n);
    s_pair(a, b) ##0 pick |-> since_q >= n;
  endproperty
  AST_SETUP: assert property (s_setup |=> pready) else $error("no access answer");
  AST_ERR: assert property (pready && paddr != TIMING_OFFSET |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_READBACK: assert property (pready && !pwrite && paddr == TIMING_OFFSET |-> prdata == sh_q)
    else $error("timing word readback wrong");
  AST_ACK: assert property (mem_cmd_valid |-> cmd_ack ##1 !mem_cmd_valid) else $error("issue pulse wrong");
  AST_WR_RD: assert property (p_gap(OP_WR, OP_RD, !same, sh_q[29] ? WR_RD_FAST : WR_RD_SLOW))
    else $error("write to read gap short");
  AST_RD_WR: assert property (p_gap(OP_RD, OP_WR, 1'b1, sh_q[28] ? RD_WR_FAST : RD_WR_SLOW))
    else $error("read to write gap short");
  AST_RD_RD: assert property (p_gap(OP_RD, OP_RD, !same, sh_q[27] ? RD_RD_FAST : RD_RD_SLOW))
    else $error("read to read gap short");
  AST_ACT_PRE: assert property (p_gap(OP_ACT, OP_PRE, same, act_pre_n))
    else $error("activate to precharge short");
  AST_ACT_WR: assert property (p_gap(OP_ACT, OP_WR, same, sh_q[3] ? RCD_FAST : RCD_SLOW))
    else $error("activate to write short");
  AST_ACT_RD: assert property (p_gap(OP_ACT, OP_RD, same, sh_q[1] ? RCD_FAST : RCD_SLOW))
    else $error("activate to read short");
  AST_PRE_ACT: assert property (p_gap(OP_PRE, OP_ACT, same, sh_q[0] ? RP_FAST : RP_SLOW))
    else $error("precharge to activate short");
  AST_RET7: assert property (rd_capture && sh_q[26:24] == 3'h0 |-> ##7 rd_return)
    else $error("read return not after 7");
  AST_RET5: assert property (rd_capture && sh_q[26:24] == 3'h2 |-> ##5 rd_return)
    else $error("read return not after 5");
endmodule : cmd_timing_asserts

bind dram_command_timing_control cmd_timing_asserts #(.ROW_W(ROW_W), .WTR_COUNT(WTR_COUNT)) i_asserts (.*);

/* File: test/mem_model.sv */
// Memory channel model: tracks open rows, counts illegal commands.
// Assumes one-cycle mem_cmd_valid pulses on pclk.
`timescale 1ns/10ps
module mem_model #(
  parameter int ROWS  = 8,
  parameter int ROW_W = 3
) (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Issued command
  input  wire logic                    mem_cmd_valid,
  input  wire cmd_timing_pkg::cmd_op_e mem_cmd_op,
  input  wire logic [ROW_W-1:0]        mem_cmd_row,
  // Illegal commands seen
  output      logic [7:0]              faults_q
);
  import cmd_timing_pkg::*;
  logic [ROWS-1:0] open_q;
  // Activate opens, precharge closes; access needs an open row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q   <= '0;
      faults_q <= 8'h00;
    end else if (mem_cmd_valid) begin
      if ((mem_cmd_op == OP_ACT) == open_q[mem_cmd_row]) faults_q <= faults_q + 8'h01;
      if (mem_cmd_op inside {OP_ACT, OP_PRE}) open_q[mem_cmd_row] <= (mem_cmd_op == OP_ACT);
    end
  end
endmodule : mem_model

/* File: test/testbench.sv */
// Self-checking bench for the command timing block.
// Assumes the checker is bound and the memory model watches issued commands.
`timescale 1ns/10ps
module testbench;
  import cmd_timing_pkg::*;
  localparam logic [3:0] WTR = 4'h2;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic        pready, pslverr, cmd_req = 1'b0, cmd_ack, mem_cmd_valid, rd_capture = 1'b0, rd_return;
  cmd_op_e     cmd_op = OP_ACT, mem_cmd_op;
  logic [2:0]  cmd_row = 3'h0, mem_cmd_row, read_latency_half;
  logic [7:0]  faults_q;
  int          fails = 0, compares = 0, cyc = 0, last = 0, g, n;
  logic [31:0] rd_q[$];
  int          gap_q[$];
  dram_command_timing_control #(.WTR_COUNT(WTR)) i_dut (.*);
  mem_model i_mem (.*);
  always #4 pclk = ~pclk;
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    check({31'h0, pslverr}, {31'h0, err});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0, err);
  endtask : rd
  task automatic cmd(input cmd_op_e op, input int row, input int gap);
    gap_q.push_back(gap);
    cmd_req <= 1'b1;
    cmd_op  <= op;
    cmd_row <= 3'(row);
    do @(posedge pclk); while (cmd_ack !== 1'b1);
  endtask : cmd
  // Output watcher: read data and issue spacing
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite) check(prdata, rd_q.pop_front());
    if (cmd_ack === 1'b1) begin
      g = gap_q.pop_front();
      if (g != 0) check(32'(cyc - last), 32'(g));
      last = cyc;
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    complete_run();
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(34));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(TIMING_OFFSET, TIMING_RESET, 1'b0);
    check({29'h0, read_latency_half}, 32'h4);
    rd(12'h07C, 32'h0, 1'b1);
    apb(1'b1, 12'h07C, 32'hFFFFFFFF, 1'b1);
    rd(TIMING_OFFSET, TIMING_RESET, 1'b0);
    $display("register test done");
    for (int k = 0; k < 4; k++) begin
      v = ($urandom & 32'h3800000B) | (32'($urandom % 3) << 24) | (32'($urandom % 3) << 9) | (32'($urandom % 3) << 4);
      if (k == 0) v = TIMING_RESET;
      if (k == 1) v = 32'h3A00042B;
      apb(1'b1, TIMING_OFFSET, (k == 3) ? (v | ~TIMING_WR_MASK) : v, 1'b0);
      rd(TIMING_OFFSET, v, 1'b0);
      check({29'h0, read_latency_half}, 32'(3'h5 - v[5:4]));
      rd_capture <= 1'b1;
      @(posedge pclk);
      rd_capture <= 1'b0;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (rd_return !== 1'b1 && n < 20);
      check(32'(n), 32'(7 - v[25:24]));
      cmd(OP_ACT, 1, 0);
      cmd(OP_ACT, 0, 2);
      cmd(OP_RD, 0, v[1] ? 2 : 3);
      cmd(OP_RD, 1, v[27] ? 3 : 4);
      cmd(OP_WR, 0, v[28] ? 4 : 5);
      cmd(OP_RD, 1, v[29] ? 2 : 3);
      cmd(OP_WR, 1, v[28] ? 4 : 5);
      cmd(OP_RD, 1, WTR);
      cmd(OP_ACT, 2, 2);
      cmd(OP_PRE, 2, 7 - v[10:9]);
      cmd(OP_ACT, 2, v[0] ? 2 : 3);
      cmd(OP_PRE, 2, 7 - v[10:9]);
      cmd(OP_PRE, 0, 2);
      cmd(OP_PRE, 1, 2);
      cmd(OP_ACT, 3 + k, 2);
      cmd(OP_WR, 3 + k, v[3] ? 2 : 3);
      cmd_req <= 1'b0;
      $display("config %0d done", k);
    end
    check({24'h0, faults_q}, 32'h0);
    complete_run();
  end
endmodule : testbench
